// [design/esd_off_timer.v]
`timescale 1ns/10ps
`include "rail_status_control_regs.vh"

// Counts an emergency-shutdown off interval; busy while counting
module esd_off_timer #(
    parameter [24:0] CYC_0 = 25'd250000,
    parameter [24:0] CYC_1 = 25'd1250000,
    parameter [24:0] CYC_2 = 25'd2500000,
    parameter [24:0] CYC_3 = 25'd25000000
) (
    input wire ref_clk_i,
    input wire reset_i,
    input wire start_i,
    input wire [1:0] sel_i,
    output wire busy_o
);

    reg [`ESD_CNT_W-1:0] count_r;
    wire [`ESD_CNT_W-1:0] one_c;

    assign one_c = {{(`ESD_CNT_W-1){1'b0}}, 1'b1};

    // Load interval less the start cycle, then count down to zero
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            count_r <= {`ESD_CNT_W{1'b0}};
        end else if (start_i) begin
            case (sel_i)
                2'h0: count_r <= CYC_0 - one_c;
                2'h1: count_r <= CYC_1 - one_c;
                2'h2: count_r <= CYC_2 - one_c;
                default: count_r <= CYC_3 - one_c;
            endcase
        end else if (count_r != {`ESD_CNT_W{1'b0}}) begin
            count_r <= count_r - {{(`ESD_CNT_W-1){1'b0}}, 1'b1};
        end
    end

    assign busy_o = (count_r != {`ESD_CNT_W{1'b0}});

endmodule // esd_off_timer

// [design/rail_status_control_regs.v]
// Register access over APB was decided locally.
`timescale 1ns/10ps
`include "rail_status_control_regs.vh"

// What this block does
// RQ1 - Discharge field bits 7-6 picks none, 100, 200 or 500 ohm
// RQ2 - Participation bit 0: regulator forced off during emergency interval
// RQ3 - Participation bit 1: only the enable bit governs the regulator
// RQ4 - Voltage code bits 4-1 held and driven to the regulator
// RQ5 - Bit 0 enables regulator; whole control register read/write
// RQ6 - Status A: second linear rail bit 7, step-down six..one bits 5..0
// RQ7 - Status A at B0h, resets zero, fully read-only
// RQ8 - Status B: five volt bit 5, aux 4, termination 3, third linear 0
// RQ9 - Status B at B1h, resets zero, read-only, reserved read zero
// RQ10 - Fault A bit sets when its rail loses regulation
// RQ11 - Fault bit stays set until host writes one to it
// RQ12 - Fault A at B2h, resets to zero
// RQ13 - Writing zero keeps fault bit; fault survives regulation recovery
// RQ14 - Reserved status and fault bits read zero, writes ignored
module rail_status_control_regs #(
    parameter [24:0] ESD_CYC_0 = `ESD_TIME_0_US * `CLK_MHZ,
    parameter [24:0] ESD_CYC_1 = `ESD_TIME_1_US * `CLK_MHZ,
    parameter [24:0] ESD_CYC_2 = `ESD_TIME_2_US * `CLK_MHZ,
    parameter [24:0] ESD_CYC_3 = `ESD_TIME_3_US * `CLK_MHZ
) (
    input wire ref_clk_i,
    input wire reset_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [3:0] pstrb_i,
    output reg [31:0] prdata_o,
    output wire pready_o,
    output wire pslverr_o,
    input wire second_linear_in_range_i,
    input wire [5:0] step_down_in_range_i,
    input wire fixed_five_in_range_i,
    input wire aux_in_range_i,
    input wire termination_in_range_i,
    input wire third_linear_in_range_i,
    input wire emergency_shutdown_i,
    output wire [1:0] aux_discharge_select_o,
    output wire [3:0] aux_voltage_code_o,
    output wire aux_regulator_on_o,
    output wire irq_o
);

    // ************************************************************
    // Bus decode
    // ************************************************************
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_ACCESS = 2'h1;
    localparam [1:0] ST_DONE = 2'h2;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [7:0] aux_ctrl_r;
    reg [7:0] pg_a_r;
    reg [7:0] pg_b_r;
    reg [7:0] fault_a_r;
    reg [7:0] fault_a_nxt;
    reg [7:0] prev_pg_a_r;
    reg [7:0] irq_mask_r;
    reg [1:0] esd_sel_r;
    reg esd_prev_r;
    reg esd_seen_r;
    reg [7:0] rd_mux;
    wire [7:0] idx;
    wire addr_ok;
    wire access;
    wire wr_en;
    wire lane0;
    wire [7:0] wbyte;
    wire [7:0] pg_a_now;
    wire [7:0] pg_b_now;
    wire [7:0] loss_a;
    wire esd_start;
    wire esd_busy;

    // Word index from byte address; upper and low bits must match
    function hit;
        input [7:0] index;
        input [7:0] target;
        begin
            hit = (index == target);
        end
    endfunction

    assign idx = paddr_i[9:2];
    assign addr_ok = (paddr_i[1:0] == 2'h0) && (paddr_i[11:10] == 2'h0) &&
        (hit(idx, `IDX_AUX_CTRL) || hit(idx, `IDX_PG_STATUS_A) ||
         hit(idx, `IDX_PG_STATUS_B) || hit(idx, `IDX_FAULT_A) ||
         hit(idx, `IDX_IRQ_MASK) || hit(idx, `IDX_ESD_CTRL) ||
         hit(idx, `IDX_ESD_STATUS));
    assign access = psel_i && penable_i && (state_r == ST_ACCESS);
    assign wr_en = access && pwrite_i && addr_ok && lane0;
    assign lane0 = pstrb_i[0];
    assign wbyte = pwdata_i[7:0];

    // No wait state: setup, then answer in the first access cycle
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (psel_i && !penable_i) begin
                    state_nxt = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                state_nxt = ST_DONE;
            end
            ST_DONE: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // Ready and error are valid in the access phase only
    assign pready_o = access;
    assign pslverr_o = access && !addr_ok;

    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_r <= ST_IDLE;
        end else if (state_r == ST_ACCESS) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ************************************************************
    // Control, interrupt mask and shutdown select registers
    // ************************************************************
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            aux_ctrl_r <= `RST_AUX_CTRL; // RQ5
            irq_mask_r <= `RST_IRQ_MASK;
            esd_sel_r <= 2'h0;
        end else if (wr_en) begin
            if (hit(idx, `IDX_AUX_CTRL)) begin
                aux_ctrl_r <= wbyte; // RQ5
            end
            if (hit(idx, `IDX_IRQ_MASK)) begin
                irq_mask_r <= wbyte & `FAULT_A_VALID;
            end
            if (hit(idx, `IDX_ESD_CTRL)) begin
                esd_sel_r <= wbyte[`ESD_SEL_HI:`ESD_SEL_LO];
            end
        end
    end

    // Discharge and voltage code go straight to the regulator
    assign aux_discharge_select_o =
        aux_ctrl_r[`AUX_DISCH_HI:`AUX_DISCH_LO]; // RQ1
    assign aux_voltage_code_o = aux_ctrl_r[`AUX_VID_HI:`AUX_VID_LO]; // RQ4

    // ************************************************************
    // Emergency shutdown
    // ************************************************************
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            esd_prev_r <= 1'b0;
            esd_seen_r <= 1'b0;
        end else begin
            esd_prev_r <= emergency_shutdown_i;
            if (esd_start) begin
                esd_seen_r <= 1'b1;
            end else if (wr_en && hit(idx, `IDX_ESD_STATUS) && wbyte[0]) begin
                esd_seen_r <= 1'b0;
            end
        end
    end

    assign esd_start = emergency_shutdown_i && !esd_prev_r;

    esd_off_timer #(
        .CYC_0(ESD_CYC_0),
        .CYC_1(ESD_CYC_1),
        .CYC_2(ESD_CYC_2),
        .CYC_3(ESD_CYC_3)
    ) u_esd_timer (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .start_i(esd_start),
        .sel_i(esd_sel_r),
        .busy_o(esd_busy)
    );

    // Participation clear: off while shutdown interval runs
    assign aux_regulator_on_o = aux_ctrl_r[`AUX_EN_BIT] && // RQ5
        (aux_ctrl_r[`AUX_SDWN_BIT] || // RQ3
         !(esd_busy || esd_start)); // RQ2

    // ************************************************************
    // Status and fault
    // ************************************************************
    assign pg_a_now = {second_linear_in_range_i, 1'b0,
        step_down_in_range_i}; // RQ6
    assign pg_b_now = {2'h0, fixed_five_in_range_i, aux_in_range_i,
        termination_in_range_i, 2'h0, third_linear_in_range_i}; // RQ8
    assign loss_a = prev_pg_a_r & ~pg_a_now & `FAULT_A_VALID; // RQ10

    // Write one clears; a new loss in the same cycle wins
    always @* begin
        fault_a_nxt = fault_a_r;
        if (wr_en && hit(idx, `IDX_FAULT_A)) begin
            fault_a_nxt = fault_a_r & ~wbyte; // RQ11 RQ13
        end
        fault_a_nxt = (fault_a_nxt | loss_a) & `FAULT_A_VALID; // RQ10 RQ14
    end

    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            pg_a_r <= `RST_STATUS; // RQ7
            pg_b_r <= `RST_STATUS; // RQ9
            prev_pg_a_r <= `RST_STATUS;
            fault_a_r <= `RST_STATUS; // RQ12
        end else begin
            pg_a_r <= pg_a_now & `PG_A_VALID; // RQ7 RQ14
            pg_b_r <= pg_b_now & `PG_B_VALID; // RQ9 RQ14
            prev_pg_a_r <= pg_a_now;
            fault_a_r <= fault_a_nxt;
        end
    end

    // Level interrupt while any unmasked fault is pending
    assign irq_o = |(fault_a_r & irq_mask_r);

    // ************************************************************
    // Read data
    // ************************************************************
    always @* begin
        rd_mux = 8'h00;
        if (hit(idx, `IDX_AUX_CTRL)) begin
            rd_mux = aux_ctrl_r;
        end else if (hit(idx, `IDX_PG_STATUS_A)) begin
            rd_mux = pg_a_r; // RQ7
        end else if (hit(idx, `IDX_PG_STATUS_B)) begin
            rd_mux = pg_b_r; // RQ9
        end else if (hit(idx, `IDX_FAULT_A)) begin
            rd_mux = fault_a_r;
        end else if (hit(idx, `IDX_IRQ_MASK)) begin
            rd_mux = irq_mask_r;
        end else if (hit(idx, `IDX_ESD_CTRL)) begin
            rd_mux = {6'h00, esd_sel_r};
        end else if (hit(idx, `IDX_ESD_STATUS)) begin
            rd_mux = {6'h00, esd_busy, esd_seen_r};
        end
    end

    // Read data registered at setup, valid in the access phase
    always @(posedge ref_clk_i) begin
        if (reset_i) begin
            prdata_o <= 32'h00000000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            prdata_o <= addr_ok ? {24'h000000, rd_mux} : 32'h00000000;
        end
    end

endmodule // rail_status_control_regs

// [design/rail_status_control_regs.vh]
`ifndef RAIL_STATUS_CONTROL_REGS_VH
`define RAIL_STATUS_CONTROL_REGS_VH

// ****************************************************************
// Register indices (printed offsets), byte address is index times 4
// ****************************************************************
`define IDX_AUX_CTRL 8'hae
`define IDX_PG_STATUS_A 8'hb0
`define IDX_PG_STATUS_B 8'hb1
`define IDX_FAULT_A 8'hb2
`define IDX_IRQ_MASK 8'hc0
`define IDX_ESD_CTRL 8'hc1
`define IDX_ESD_STATUS 8'hc2

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_AUX_CTRL 8'h7d
`define RST_STATUS 8'h00
`define RST_IRQ_MASK 8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define AUX_DISCH_HI 7
`define AUX_DISCH_LO 6
`define AUX_SDWN_BIT 5
`define AUX_VID_HI 4
`define AUX_VID_LO 1
`define AUX_EN_BIT 0
`define PG_A_VALID 8'hbf
`define PG_B_VALID 8'h39
`define FAULT_A_VALID 8'hbf
`define ESD_CTRL_VALID 8'h03
`define ESD_SEL_HI 1
`define ESD_SEL_LO 0

// ****************************************************************
// Discharge codes
// ****************************************************************
`define DISCH_NONE 2'h0
`define DISCH_100 2'h1
`define DISCH_200 2'h2
`define DISCH_500 2'h3

// ****************************************************************
// Shutdown durations in microseconds and clock rate in MHz
// ****************************************************************
`define CLK_MHZ 250
`define ESD_TIME_0_US 1000
`define ESD_TIME_1_US 5000
`define ESD_TIME_2_US 10000
`define ESD_TIME_3_US 100000
`define ESD_CNT_W 25

`endif

// [tb/rail_status_control_regs_asserts.sv]
`timescale 1ns/10ps
module rail_status_control_regs_asserts (
    input wire ref_clk_i,
    input wire reset_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [3:0] pstrb_i,
    input wire [31:0] prdata_o,
    input wire pready_o,
    input wire pslverr_o,
    input wire emergency_shutdown_i,
    input wire [1:0] aux_discharge_select_o,
    input wire [3:0] aux_voltage_code_o,
    input wire aux_regulator_on_o
);
    // ****************************************************************
    // Shadow of the control register
    // ****************************************************************
    reg [7:0] ctrl_r;
    wire acc = psel_i && penable_i;
    wire rd = acc && !pwrite_i && pready_o;
    wire mapped = paddr_i == 12'h2b8 || paddr_i == 12'h2c0 ||
        paddr_i == 12'h2c4 || paddr_i == 12'h2c8 || paddr_i == 12'h300 ||
        paddr_i == 12'h304 || paddr_i == 12'h308;

    // Follows committed writes so outputs can be tied to their cause
    always @(posedge ref_clk_i) begin
        if (reset_i)
            ctrl_r <= 8'h7d;
        else if (acc && pwrite_i && pready_o && pstrb_i[0] &&
                 paddr_i == 12'h2b8)
            ctrl_r <= pwdata_i[7:0];
    end

    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    AST_ANSWER: assert property (acc |-> pready_o && pslverr_o == !mapped)
        else $error("bad bus answer");
    AST_DISCHARGE: assert property (aux_discharge_select_o == ctrl_r[7:6])
        else $error("discharge select mismatch");
    AST_VOLTAGE: assert property (aux_voltage_code_o == ctrl_r[4:1])
        else $error("voltage code mismatch");
    AST_OFF: assert property (!ctrl_r[0] |-> !aux_regulator_on_o)
        else $error("regulator on while disabled");
    AST_FOLLOW: assert property (ctrl_r[5] |-> aux_regulator_on_o == ctrl_r[0])
        else $error("regulator not following enable");
    AST_SHUTDOWN: assert property ($rose(emergency_shutdown_i) && !ctrl_r[5]
        |-> ##[0:1] !aux_regulator_on_o) else $error("shutdown ignored");
    AST_RSV_A: assert property (rd && (paddr_i == 12'h2c0 ||
        paddr_i == 12'h2c8) |-> !prdata_o[6]) else $error("reserved bit set");
    AST_RSV_B: assert property (rd && paddr_i == 12'h2c4 |->
        prdata_o[7:6] == 2'h0 && prdata_o[2:1] == 2'h0)
        else $error("reserved bits set");

    CV_SHUTDOWN: cover property ($rose(emergency_shutdown_i) && !ctrl_r[5]);
    CV_UNMAPPED: cover property (acc && !mapped);
    CV_FAULT: cover property (rd && paddr_i == 12'h2c8 && prdata_o[7:0] != 8'h0);
endmodule // rail_status_control_regs_asserts

bind rail_status_control_regs rail_status_control_regs_asserts
    u_rail_status_control_regs_asserts (.ref_clk_i(ref_clk_i),
    .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .emergency_shutdown_i(emergency_shutdown_i),
    .aux_discharge_select_o(aux_discharge_select_o),
    .aux_voltage_code_o(aux_voltage_code_o),
    .aux_regulator_on_o(aux_regulator_on_o));

// [tb/rail_status_control_regs_tb.sv]
`timescale 1ns/10ps
module rail_status_control_regs_tb;
    reg ref_clk_i = 1'b0, reset_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
    reg pwrite_i = 1'b0, lin2 = 1'b0, five = 1'b0, aux = 1'b0, term = 1'b0;
    reg lin3 = 1'b0, esd = 1'b0, err_v;
    reg [11:0] paddr_i = 12'h0;
    reg [31:0] pwdata_i = 32'h0, rd_v;
    reg [5:0] step = 6'h0;
    reg [7:0] cv;
    wire [31:0] prdata_o;
    wire pready_o, pslverr_o, on_o, irq_o;
    wire [1:0] disch_o;
    wire [3:0] vid_o;
    integer failures = 0, samples_checked = 0, n, i;

    // Free-running clock
    always #2 ref_clk_i = ~ref_clk_i;

    rail_status_control_regs #(.ESD_CYC_0(25'd4), .ESD_CYC_1(25'd8),
        .ESD_CYC_2(25'd16), .ESD_CYC_3(25'd32)) u_rail_status_control_regs (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .pstrb_i(4'hf), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o),
        .second_linear_in_range_i(lin2), .step_down_in_range_i(step),
        .fixed_five_in_range_i(five), .aux_in_range_i(aux),
        .termination_in_range_i(term), .third_linear_in_range_i(lin3),
        .emergency_shutdown_i(esd), .aux_discharge_select_o(disch_o),
        .aux_voltage_code_o(vid_o), .aux_regulator_on_o(on_o), .irq_o(irq_o));

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task chk(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("unexpected at %0t: got %h expected %h", $time, got,
                    exp);
            end
        end
    endtask

    // One APB transfer, held until pready is sampled high
    task apb(input wr, input [11:0] a, input [31:0] d);
        integer k;
        begin
            @(posedge ref_clk_i);
            psel_i <= 1'b1;
            pwrite_i <= wr;
            paddr_i <= a;
            pwdata_i <= d;
            @(posedge ref_clk_i);
            penable_i <= 1'b1;
            k = 0;
            do begin
                @(posedge ref_clk_i);
                k = k + 1;
            end while (pready_o !== 1'b1 && k < 50);
            rd_v = prdata_o;
            err_v = pslverr_o;
            if (k >= 50)
                failures = failures + 1;
            psel_i <= 1'b0;
            penable_i <= 1'b0;
        end
    endtask

    task wr(input [11:0] a, input [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rd(input [11:0] a, input [31:0] exp);
        begin
            apb(1'b0, a, 32'h0);
            chk(rd_v, exp);
        end
    endtask

    task give_verdict;
        begin
            $display("checks %0d failures %0d", samples_checked, failures);
            if (failures == 0 && samples_checked > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    // Watchdog against a hung handshake
    initial begin
        #40000;
        failures = failures + 1;
        give_verdict;
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (4) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        rd(12'h2b8, 32'h7d);
        rd(12'h2c0, 32'h0);
        rd(12'h2c4, 32'h0);
        rd(12'h2c8, 32'h0);
        $display("test reset done");
        for (i = 0; i < 4; i = i + 1) begin
            cv = {i[1:0], 1'b1, 4'h5 ^ {i[1:0], i[1:0]}, i[0]};
            wr(12'h2b8, {24'h0, cv});
            rd(12'h2b8, {24'h0, cv});
            chk({30'h0, disch_o}, {30'h0, cv[7:6]});
            chk({28'h0, vid_o}, {28'h0, cv[4:1]});
            chk({31'h0, on_o}, {31'h0, cv[0]});
        end
        $display("test control done");
        {lin2, step, five, aux, term, lin3} <= 11'h7ff;
        rd(12'h2c0, 32'hbf);
        rd(12'h2c4, 32'h39);
        wr(12'h2c0, 32'h0);
        rd(12'h2c0, 32'hbf);
        wr(12'h2c4, 32'hff);
        rd(12'h2c4, 32'h39);
        rd(12'h2c8, 32'h0);
        lin2 <= 1'b0;
        step <= 6'h2a;
        five <= 1'b0;
        rd(12'h2c0, 32'h2a);
        rd(12'h2c4, 32'h19);
        rd(12'h2c8, 32'h95);
        {lin2, step, five} <= 8'hff;
        wr(12'h2c8, 32'h0);
        rd(12'h2c8, 32'h95);
        chk({31'h0, irq_o}, 32'h0);
        wr(12'h300, 32'h04);
        @(negedge ref_clk_i);
        chk({31'h0, irq_o}, 32'h1);
        wr(12'h2c8, 32'h05);
        rd(12'h2c8, 32'h90);
        @(negedge ref_clk_i);
        chk({31'h0, irq_o}, 32'h0);
        wr(12'h2c8, 32'hff);
        rd(12'h2c8, 32'h0);
        apb(1'b0, 12'h3fc, 32'h0);
        chk({31'h0, err_v}, 32'h1);
        chk(rd_v, 32'h0);
        $display("test status done");
        for (i = 0; i < 5; i = i + 1) begin
            wr(12'h304, i % 4);
            wr(12'h2b8, (i == 4) ? 32'h21 : 32'h01);
            esd <= 1'b1;
            n = 0;
            repeat (60) begin
                @(posedge ref_clk_i);
                if (on_o === 1'b0)
                    n = n + 1;
            end
            chk(n, (i == 4) ? 0 : 4 << i);
            esd <= 1'b0;
        end
        $display("test shutdown done");
        give_verdict;
    end
endmodule // rail_status_control_regs_tb
